// *** src/wid_top.sv ***
// Purpose: Wake-up and interrupt dispatch with AHB-Lite register access
// Assumes: Events and instruction strobes come from logic on mclk
// Notes:   Green and normal mode dispatch alike; green is a status flag
`timescale 1ns/10ps

module wid_top (
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [1:0]  hresp,
	output logic      [31:0] hrdata,
	input  wire logic        ev_timer_ovf,
	input  wire logic        ev_second_timer,
	input  wire logic        ev_pwm_a,
	input  wire logic        ev_pwm_b,
	input  wire logic        ev_iic_tx,
	input  wire logic        ev_iic_rx,
	input  wire logic        ev_iic_rx_addr_match,
	input  wire logic        ev_iic_stop,
	input  wire logic        global_int_on_instr,
	input  wire logic        global_int_off_instr,
	input  wire logic        sleep_instr,
	input  wire logic        wdt_reset,
	output logic             irq,
	output logic             vector_req,
	output logic             core_halted,
	output logic             wake_pulse,
	output logic      [7:0]  special_bank_sel,
	output logic      [7:0]  general_bank_sel
);

	logic [1:0]               rst_sync_reg;
	logic                     rst_n;
	logic                     dp_valid_reg;
	logic                     dp_write_reg;
	logic [2:0]               dp_idx_reg;
	logic                     ap_take;
	logic                     ap_mapped;
	logic [31:0]              hrdata_reg;
	logic [7:0]               iap_reg;
	logic [7:0]               bank_reg;
	logic [1:0]               ctrl_reg;
	logic [wid_pkg::NSRC-1:0] en_reg;
	logic [wid_pkg::NSRC-1:0] stat_reg;
	logic [wid_pkg::NSRC-1:0] stat_next;
	logic [wid_pkg::NSRC-1:0] clr_vec;
	logic [wid_pkg::NSRC-1:0] ev_vec;
	logic                     gie_reg;
	logic                     wake_pulse_reg;
	logic                     irq_reg;
	logic                     vector_req_reg;
	logic                     pending;
	wid_pkg::wid_state_t      state_reg;
	wid_pkg::wid_state_t      state_next;

	wid_dec_if dec_bus ();

	// Reset release through two flip-flops
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_reg <= wid_pkg::RST_SYNC_RST;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_reg[1];

	// Event vector in source-bit order
	always_comb begin
		ev_vec = wid_pkg::SRC_RST;
		ev_vec[wid_pkg::SRC_TMR_OVF]  = ev_timer_ovf;
		ev_vec[wid_pkg::SRC_TMR2]     = ev_second_timer;
		ev_vec[wid_pkg::SRC_PWM_A]    = ev_pwm_a;
		ev_vec[wid_pkg::SRC_PWM_B]    = ev_pwm_b;
		ev_vec[wid_pkg::SRC_IIC_TX]   = ev_iic_tx;
		ev_vec[wid_pkg::SRC_IIC_RX]   = ev_iic_rx;
		ev_vec[wid_pkg::SRC_IIC_STOP] = ev_iic_stop;
	end

	// Write strobe for one register in the data phase
	function automatic logic wr_hit(input logic [2:0] idx);
		wr_hit = dp_valid_reg && dp_write_reg && (dp_idx_reg == idx);
	endfunction

	// Index is one of the mapped registers
	function automatic logic idx_mapped(input logic [2:0] idx);
		idx_mapped = (idx != 3'h2);
	endfunction

	// Read value of a register; write-only and unmapped read zero
	function automatic logic [31:0] read_value(input logic [2:0] idx);
		read_value = 32'h0000_0000;
		unique case (idx)
			wid_pkg::IDX_IAP: begin
				read_value[7:0] = iap_reg;
			end
			wid_pkg::IDX_BANK: begin
				read_value[7:0] = bank_reg & wid_pkg::BANK_MASK;
			end
			wid_pkg::IDX_CTRL: begin
				read_value[1:0] = ctrl_reg;
			end
			wid_pkg::IDX_STAT: begin
				read_value[wid_pkg::NSRC-1:0] = stat_reg;
			end
			wid_pkg::IDX_EN: begin
				read_value[wid_pkg::NSRC-1:0] = en_reg;
			end
			wid_pkg::IDX_CORE: begin
				read_value[wid_pkg::CORE_HALT_BIT] =
					(state_reg != wid_pkg::WID_RUN);
				read_value[wid_pkg::CORE_GIE_BIT] = gie_reg;
				read_value[wid_pkg::CORE_IDLE_BIT] =
					(state_reg == wid_pkg::WID_IDLE);
				read_value[wid_pkg::CORE_GREEN_BIT] =
					ctrl_reg[wid_pkg::CTRL_GREEN_BIT];
			end
			default: begin
				read_value = 32'h0000_0000;
			end
		endcase
	endfunction

	// Address phase: selected NONSEQ/SEQ word access below 0x20
	assign ap_take   = hsel && hready && htrans[1];
	assign ap_mapped = (haddr[31:5] == 27'h000_0000) &&
		(haddr[1:0] == 2'h0) && (hsize == 3'h2) &&
		idx_mapped(haddr[4:2]);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dp_valid_reg <= 1'b0;
			dp_write_reg <= 1'b0;
			dp_idx_reg   <= 3'h0;
		end else if (hready) begin
			dp_valid_reg <= ap_take && ap_mapped;
			dp_write_reg <= hwrite;
			dp_idx_reg   <= haddr[4:2];
		end
	end

	// Read data captured at the address phase, held in the data phase
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_reg <= 32'h0000_0000;
		end else if (ap_take && !hwrite) begin
			hrdata_reg <= ap_mapped ? read_value(haddr[4:2]) :
				32'h0000_0000;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = wid_pkg::HRESP_OKAY;
	assign hrdata    = hrdata_reg;

	// Indirect access port: plain storage
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			iap_reg <= wid_pkg::IAP_RST;
		end else if (wr_hit(wid_pkg::IDX_IAP)) begin
			iap_reg <= hwdata[7:0];
		end
	end

	// Bank select: two live bits; cleared by reset and watchdog reset
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bank_reg <= wid_pkg::BANK_RST;
		end else if (wdt_reset) begin
			bank_reg <= wid_pkg::BANK_RST;
		end else if (wr_hit(wid_pkg::IDX_BANK)) begin
			bank_reg <= hwdata[7:0] & wid_pkg::BANK_MASK;
		end
	end

	assign special_bank_sel = {7'h00, bank_reg[wid_pkg::BANK_SPECIAL_BIT]};
	assign general_bank_sel = {7'h00, bank_reg[wid_pkg::BANK_GENERAL_BIT]};

	// Control: idle-versus-sleep select and green-mode flag
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= wid_pkg::CTRL_RST;
		end else if (wr_hit(wid_pkg::IDX_CTRL)) begin
			ctrl_reg <= hwdata[1:0];
		end
	end

	// Per-source interrupt enables
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			en_reg <= wid_pkg::SRC_RST;
		end else if (wr_hit(wid_pkg::IDX_EN)) begin
			en_reg <= hwdata[wid_pkg::NSRC-1:0];
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	assign clr_vec = wr_hit(wid_pkg::IDX_CLR) ? hwdata[wid_pkg::NSRC-1:0] :
		wid_pkg::SRC_RST;
	assign stat_next = (stat_reg & ~clr_vec) | ev_vec;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			stat_reg <= wid_pkg::SRC_RST;
		end else begin
			stat_reg <= stat_next;
		end
	end

	// Global interrupt enable follows the last on/off instruction
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gie_reg <= 1'b0;
		end else if (global_int_off_instr) begin
			gie_reg <= 1'b0;
		end else if (global_int_on_instr) begin
			gie_reg <= 1'b1;
		end
	end

	// Wake decoder
	assign dec_bus.state    = state_reg;
	assign dec_bus.en       = en_reg;
	assign dec_bus.ev       = ev_vec;
	assign dec_bus.rx_match = ev_iic_rx_addr_match;

	wid_wake_dec u_dec (
		.d (dec_bus.dec)
	);

	// Power state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			wid_pkg::WID_RUN: begin
				if (sleep_instr) begin
					state_next = ctrl_reg[wid_pkg::CTRL_IDLE_BIT] ?
						wid_pkg::WID_IDLE : wid_pkg::WID_SLEEP;
				end
			end
			wid_pkg::WID_SLEEP: begin
				if (dec_bus.wake) begin
					state_next = wid_pkg::WID_RUN;
				end
			end
			wid_pkg::WID_IDLE: begin
				if (dec_bus.wake) begin
					state_next = wid_pkg::WID_RUN;
				end
			end
			default: begin
				state_next = wid_pkg::WID_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= wid_pkg::WID_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// One-cycle pulse on the return to run
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_pulse_reg <= 1'b0;
		end else begin
			wake_pulse_reg <= (state_reg != wid_pkg::WID_RUN) &&
				dec_bus.wake;
		end
	end

	// Enabled pending source; disabled sources never interrupt
	assign pending = |(stat_next & en_reg);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= pending;
		end
	end

	// Vector only while running with global enable, else next instruction
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vector_req_reg <= 1'b0;
		end else begin
			vector_req_reg <= pending && gie_reg &&
				(state_next == wid_pkg::WID_RUN);
		end
	end

	assign irq         = irq_reg;
	assign vector_req  = vector_req_reg;
	assign wake_pulse  = wake_pulse_reg;
	assign core_halted = (state_reg != wid_pkg::WID_RUN);

endmodule

// *** include/wid_pkg.sv ***
// Purpose: Shared constants and types for the wake-up/interrupt dispatcher
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   Register byte address is four times the register index
package wid_pkg;

	localparam int         NSRC          = 7;
	localparam int         IDX_W         = 3;

	// Register indices (byte address = index * 4)
	localparam logic [2:0] IDX_IAP       = 3'h0;
	localparam logic [2:0] IDX_BANK      = 3'h1;
	localparam logic [2:0] IDX_CTRL      = 3'h3;
	localparam logic [2:0] IDX_STAT      = 3'h4;
	localparam logic [2:0] IDX_CLR       = 3'h5;
	localparam logic [2:0] IDX_EN        = 3'h6;
	localparam logic [2:0] IDX_CORE      = 3'h7;

	// Event source bit positions
	localparam int         SRC_TMR_OVF   = 0;
	localparam int         SRC_TMR2      = 1;
	localparam int         SRC_PWM_A     = 2;
	localparam int         SRC_PWM_B     = 3;
	localparam int         SRC_IIC_TX    = 4;
	localparam int         SRC_IIC_RX    = 5;
	localparam int         SRC_IIC_STOP  = 6;

	// Sources allowed to wake from idle when enabled
	localparam logic [6:0] IDLE_WAKE_MASK = 7'h0f;

	// Bank select layout
	localparam int         BANK_SPECIAL_BIT = 4;
	localparam int         BANK_GENERAL_BIT = 0;
	localparam logic [7:0] BANK_MASK     = 8'h11;

	// Control and core-state fields
	localparam int         CTRL_IDLE_BIT  = 0;
	localparam int         CTRL_GREEN_BIT = 1;
	localparam int         CORE_HALT_BIT  = 0;
	localparam int         CORE_GIE_BIT   = 1;
	localparam int         CORE_IDLE_BIT  = 2;
	localparam int         CORE_GREEN_BIT = 3;

	// Reset values
	localparam logic [7:0] IAP_RST       = 8'h00;
	localparam logic [7:0] BANK_RST      = 8'h00;
	localparam logic [1:0] CTRL_RST      = 2'h0;
	localparam logic [6:0] SRC_RST       = 7'h00;
	localparam logic [1:0] RST_SYNC_RST  = 2'h0;
	localparam logic [1:0] HRESP_OKAY    = 2'h0;

	typedef enum logic [2:0] {
		WID_RUN   = 3'b001,
		WID_SLEEP = 3'b010,
		WID_IDLE  = 3'b100
	} wid_state_t;

endpackage

// *** include/wid_dec_if.sv ***
// Purpose: Carries power state, enables and events to the wake decoder
// Assumes: Same clock domain on both sides
// Notes:   Purely combinational bundle
`timescale 1ns/10ps
interface wid_dec_if;
	wid_pkg::wid_state_t         state;
	logic [wid_pkg::NSRC-1:0]    en;
	logic [wid_pkg::NSRC-1:0]    ev;
	logic                        rx_match;
	logic                        wake;

	modport top (output state, output en, output ev, output rx_match,
		input wake);
	modport dec (input state, input en, input ev, input rx_match,
		output wake);
endinterface

// *** src/wid_wake_dec.sv ***
// Purpose: Decides whether the current events wake the halted core
// Assumes: Events are one-cycle pulses from logic on the same clock
// Notes:   Combinational only
`timescale 1ns/10ps
module wid_wake_dec (
	wid_dec_if.dec d
);

	logic idle_wake;

	// Enabled timer and PWM sources wake from idle only
	assign idle_wake = |(d.ev & d.en & wid_pkg::IDLE_WAKE_MASK);

	always_comb begin
		d.wake = 1'b0;
		unique case (d.state)
			wid_pkg::WID_SLEEP: begin
				d.wake = d.rx_match;
			end
			wid_pkg::WID_IDLE: begin
				d.wake = idle_wake | d.rx_match;
			end
			wid_pkg::WID_RUN: begin
				d.wake = 1'b0;
			end
		endcase
	end

endmodule

// *** dv/wid_top_asserts.sv ***
// Purpose: Port-level checks of wake and interrupt dispatch
// Assumes: Bound to wid_top, one clock domain
// Notes:   Watches design outputs against event and instruction inputs
`timescale 1ns/10ps
module wid_top_asserts (
	input wire logic       mclk,
	input wire logic       nrst,
	input wire logic       irq,
	input wire logic       vector_req,
	input wire logic       core_halted,
	input wire logic       wake_pulse,
	input wire logic       ev_timer_ovf,
	input wire logic       ev_second_timer,
	input wire logic       ev_pwm_a,
	input wire logic       ev_pwm_b,
	input wire logic       ev_iic_rx_addr_match,
	input wire logic       global_int_on_instr,
	input wire logic       global_int_off_instr,
	input wire logic       sleep_instr,
	input wire logic       wdt_reset,
	input wire logic [7:0] special_bank_sel,
	input wire logic [7:0] general_bank_sel
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	AST_NO_WAKE: assert property (core_halted && !(ev_timer_ovf
		|| ev_second_timer || ev_pwm_a || ev_pwm_b
		|| ev_iic_rx_addr_match) |=> core_halted)
		else $error("halted core woke without a wake source");
	AST_RX_WAKE: assert property (core_halted && ev_iic_rx_addr_match
		|=> !core_halted && wake_pulse)
		else $error("address match did not wake the core");
	AST_WAKE_ONE: assert property (wake_pulse |=> !wake_pulse)
		else $error("wake pulse longer than one cycle");
	AST_WAKE_CAUSE: assert property (wake_pulse |->
		$past(core_halted) && !core_halted)
		else $error("wake pulse without a halted core");
	AST_VEC_IRQ: assert property (vector_req |-> irq && !core_halted)
		else $error("vector request without interrupt");
	AST_SLEEP_IN: assert property (sleep_instr && !core_halted
		|=> core_halted && !vector_req && !wake_pulse)
		else $error("sleep instruction did not halt");
	AST_GIE_OFF: assert property (global_int_off_instr
		##1 !global_int_on_instr |=> !vector_req)
		else $error("vector request after global disable");
	AST_BANK_CLR: assert property (wdt_reset |=>
		special_bank_sel == 8'h00 && general_bank_sel == 8'h00)
		else $error("bank select kept over watchdog reset");
	AST_BANK_ZERO: assert property (special_bank_sel[7:1] == 7'h00
		&& general_bank_sel[7:1] == 7'h00)
		else $error("bank select upper bits not zero");
	COV_RX: cover property (core_halted && ev_iic_rx_addr_match);
	COV_VEC: cover property ($rose(vector_req));
	COV_WDT: cover property (wdt_reset);
endmodule
bind wid_top wid_top_asserts u_chk (.mclk, .nrst, .irq, .vector_req,
	.core_halted, .wake_pulse, .ev_timer_ovf, .ev_second_timer, .ev_pwm_a,
	.ev_pwm_b, .ev_iic_rx_addr_match, .global_int_on_instr,
	.global_int_off_instr, .sleep_instr, .wdt_reset, .special_bank_sel,
	.general_bank_sel);

// *** dv/wid_top_tb_top.sv ***
// Purpose: Self-checking bench for wid_top
// Assumes: Single AHB-Lite slave, events are one-cycle pulses
// Notes:   Sweeps every source over power modes and enables
`timescale 1ns/10ps
module wid_top_tb_top;
	logic        mclk, nrst, hsel, hwrite, rd_ph, hreadyout;
	logic        irq, vector_req, core_halted, wake_pulse, wk, ir;
	logic [31:0] haddr, hwdata, hrdata, d;
	logic [1:0]  htrans, hresp;
	logic [7:0]  ev, sbs, gbs;
	logic [3:0]  ins;
	logic [2:0]  hsize;
	logic [31:0] q[$];
	int          mismatches, checked, seed;

	wid_top dut (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .ev_timer_ovf(ev[0]), .ev_second_timer(ev[1]),
		.ev_pwm_a(ev[2]), .ev_pwm_b(ev[3]), .ev_iic_tx(ev[4]),
		.ev_iic_rx(ev[5]), .ev_iic_stop(ev[6]),
		.ev_iic_rx_addr_match(ev[7]), .global_int_on_instr(ins[0]),
		.global_int_off_instr(ins[1]), .sleep_instr(ins[2]),
		.wdt_reset(ins[3]), .irq(irq), .vector_req(vector_req),
		.core_halted(core_halted), .wake_pulse(wake_pulse),
		.special_bank_sel(sbs), .general_bank_sel(gbs));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic wrap_up;
		$display("mismatches %0d checked %0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask

	// Read results are compared here, oldest note first
	always @(posedge mclk) begin
		if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
			chk("hrdata", q.pop_front(), hrdata);
			chk("hresp", 32'h0, hresp);
		end
	end

	task automatic hold;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (n >= 64) begin
			mismatches++;
			wrap_up;
		end
	endtask

	task automatic xfer(input logic w, input logic [31:0] a, v);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= a;
		hold;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		rd_ph <= !w;
		if (!w)
			q.push_back(v);
		hold;
		rd_ph <= 1'b0;
	endtask

	task automatic fire(input logic [3:0] i, input logic [7:0] e);
		@(posedge mclk);
		ins <= i;
		ev <= e;
		@(posedge mclk);
		ins <= 4'h0;
		ev <= 8'h00;
		// Callers read outputs once they have settled after the edge
		#1;
	endtask

	initial begin
		{nrst, hsel, hwrite, rd_ph, htrans, haddr, hwdata, ev, ins} = '0;
		{mismatches, checked, seed} = {32'h0, 32'h0, 32'h38};
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		repeat (3) @(posedge mclk);
		xfer(1'b0, 32'h4, 32'h0);
		xfer(1'b0, 32'h8, 32'h0);
		d = $random(seed);
		xfer(1'b1, 32'h0, d);
		xfer(1'b0, 32'h0, {24'h0, d[7:0]});
		xfer(1'b1, 32'h4, 32'hff);
		xfer(1'b0, 32'h4, 32'h11);
		chk("bank", 32'h3, {sbs[0], gbs[0]});
		fire(4'h8, 8'h00);
		xfer(1'b0, 32'h4, 32'h0);
		for (int m = 0; m < 4; m++) begin
			for (int e = 0; e < 2; e++) begin
				for (int i = 0; i < 8; i++) begin
					xfer(1'b1, 32'h14, 32'h7f);
					#1;
					chk("irq clear", 32'h0, irq);
					xfer(1'b1, 32'h18, e ? 32'h7f : 32'h0);
					d = $random(seed);
					xfer(1'b1, 32'hc, {30'h0, d[0], m != 0});
					fire(m == 3 ? 4'h2 : 4'h1, 8'h00);
					if (m != 2)
						fire(4'h4, 8'h00);
					wk = m != 2 && (i == 7 || (m != 0 && e == 1 && i < 4));
					ir = e == 1 && i < 7;
					fire(4'h0, 8'h1 << i);
					chk("halted", m != 2 && !wk, core_halted);
					chk("wake", wk, wake_pulse);
					chk("irq", ir, irq);
					chk("vector", ir && m != 3 && (m == 2 || wk),
						vector_req);
					if (i < 7)
						xfer(1'b0, 32'h10, 32'h1 << i);
					xfer(1'b0, 32'h1c, {28'h0, d[0],
						m != 0 && m != 2 && !wk, m != 3, m != 2 && !wk});
					if (core_halted === 1'b1)
						fire(4'h0, 8'h80);
				end
			end
		end
		wrap_up;
	end
endmodule
